// ---- srcr_pkg.sv ----
package srcr_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam logic [3:0] SEL_REF_CP = 4'h4;
  localparam logic [3:0] SEL_FIXED = 4'h5;
  localparam logic [3:0] SEL_OUT_CFG = 4'h6;
  localparam logic [3:0] SEL_INTEGER = 4'h0;
  localparam logic [31:0] FIXED_WORD = 32'h00800025;
  localparam logic [31:0] OUT_CFG_BASE = 32'h14000006;
  localparam logic [31:0] REF_CP_BASE = 32'h00000004;
  localparam int unsigned TEST_SEL_HI = 29;
  localparam int unsigned TEST_SEL_LO = 27;
  localparam int unsigned DOUBLER_BIT = 26;
  localparam int unsigned HALVING_BIT = 25;
  localparam int unsigned R_CNT_HI = 24;
  localparam int unsigned R_CNT_LO = 15;
  localparam int unsigned DBUF_BIT = 14;
  localparam int unsigned CP_HI = 13;
  localparam int unsigned CP_LO = 10;
  localparam int unsigned REF_MODE_BIT = 9;
  localparam int unsigned LEVEL_BIT = 8;
  localparam int unsigned POL_BIT = 7;
  localparam int unsigned PD_BIT = 6;
  localparam int unsigned HIZ_BIT = 5;
  localparam int unsigned CRST_BIT = 4;
  localparam int unsigned GATED_BIT = 30;
  localparam int unsigned NEG_BIT = 29;
  localparam int unsigned FB_BIT = 24;
  localparam int unsigned DIV_HI = 23;
  localparam int unsigned DIV_LO = 21;
  localparam int unsigned BLEED_HI = 20;
  localparam int unsigned BLEED_LO = 13;
  localparam int unsigned MUTE_BIT = 11;
  localparam int unsigned AUX_EN_BIT = 9;
  localparam int unsigned AUX_PW_HI = 8;
  localparam int unsigned AUX_PW_LO = 7;
  localparam int unsigned PRI_EN_BIT = 6;
  localparam int unsigned PRI_PW_HI = 5;
  localparam int unsigned PRI_PW_LO = 4;
  localparam logic [5:0] BIT_CNT_LAST = 6'h1f;
  localparam logic [7:0] HOST_DIV_HALF = 8'h01;
endpackage

// ---- srcr_if.sv ----
`timescale 1ns/10ps
interface srcr_if;
  logic ser_clk;
  logic ser_data;
  logic ser_load_en;
  modport device (input ser_clk, input ser_data, input ser_load_en);
  modport host (output ser_clk, output ser_data, output ser_load_en);
endinterface

// ---- srcr_host.sv ----
`timescale 1ns/10ps
// Host end: shifts a 32-bit word MSB first, clock made by divider, load strobe after.
module srcr_host
  import srcr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [31:0] word_in,
  input wire logic word_valid_in,
  output logic word_ready_out,
  srcr_if.host link
);
  typedef enum logic [1:0] {SRCR_IDLE = 2'b00, SRCR_SHIFT = 2'b01, SRCR_LOAD = 2'b11} srcr_hst_t;
  srcr_hst_t state_q;
  logic [31:0] shift_q;
  logic [5:0] bits_q;
  logic [7:0] div_q;
  logic sclk_q;
  logic le_q;
  logic tick;
  assign tick = (div_q == HOST_DIV_HALF);
  assign word_ready_out = (state_q == SRCR_IDLE);
  assign link.ser_clk = sclk_q;
  assign link.ser_data = shift_q[31];
  assign link.ser_load_en = le_q;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 8'h00;
    end else if (state_q == SRCR_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Word content is the caller's; selector and fixed patterns are its duty
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= SRCR_IDLE;
      shift_q <= '0;
      bits_q <= 6'h00;
      sclk_q <= 1'b0;
      le_q <= 1'b0;
    end else begin
      unique case (state_q)
        SRCR_IDLE: begin
          le_q <= 1'b0;
          if (word_valid_in) begin
            shift_q <= word_in;
            bits_q <= 6'h00;
            state_q <= SRCR_SHIFT;
          end
        end
        SRCR_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              if (bits_q == BIT_CNT_LAST) begin
                state_q <= SRCR_LOAD;
              end else begin
                shift_q <= {shift_q[30:0], 1'b0};
                bits_q <= bits_q + 6'h01;
              end
            end
          end
        end
        SRCR_LOAD: begin
          if (tick) begin
            if (le_q) begin
              state_q <= SRCR_IDLE;
            end
            le_q <= ~le_q;
          end
        end
      endcase
    end
  end
endmodule

// ---- srcr_device.sv ----
`timescale 1ns/10ps
module srcr_device
  import srcr_pkg::*;
#(
  parameter int unsigned R_W = 10
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic lock_detect_in,
  srcr_if.device link,
  output logic [2:0] test_pin_select_out,
  output logic test_pin_logic_level_out,
  output logic reference_doubler_enable_out,
  output logic reference_halving_enable_out,
  output logic detector_edge_both_out,
  output logic [R_W-1:0] r_ratio_out,
  output logic r_tick_out,
  output logic phase_detector_ref_out,
  output logic [3:0] pump_current_code_out,
  output logic reference_differential_out,
  output logic detector_polarity_out,
  output logic pump_high_impedance_out,
  output logic counters_held_out,
  output logic osc_enable_out,
  output logic lock_detect_reset_out,
  output logic negative_bleed_on_out,
  output logic [7:0] bleed_current_code_out,
  output logic feedback_source_select_out,
  output logic [2:0] output_divider_code_out,
  output logic primary_rf_output_on_out,
  output logic [1:0] primary_power_out,
  output logic auxiliary_rf_output_on_out,
  output logic [1:0] auxiliary_power_out,
  output logic [31:0] fixed_word_out
);
  // Link domain: serial shift on ser_clk rising edge
  logic [31:0] shreg_q;
  logic [31:0] word_q;
  logic le_d1_q;
  logic le_d2_q;
  logic le_d3_q;
  logic [31:0] ref_cp_q;
  logic [31:0] out_cfg_q;
  logic [31:0] fixed_q;
  logic [2:0] div_active_q;
  logic [R_W-1:0] r_cnt_q;
  logic half_q;
  logic lock_s1_q;
  logic lock_s2_q;
  logic load_pulse;
  logic load_q;
  logic [3:0] sel;
  logic pd;
  logic locked;
  logic rf_allowed;

  always_ff @(posedge link.ser_clk or posedge rst_in) begin
    if (rst_in) begin
      shreg_q <= '0;
    end else begin
      shreg_q <= {shreg_q[30:0], link.ser_data};
    end
  end

  // Clock stops while load strobe is high, so the word is stable to sample
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      le_d1_q <= 1'b0;
      le_d2_q <= 1'b0;
      le_d3_q <= 1'b0;
    end else begin
      le_d1_q <= link.ser_load_en;
      le_d2_q <= le_d1_q;
      le_d3_q <= le_d2_q;
    end
  end

  assign load_pulse = le_d2_q & ~le_d3_q;

  // Decode one edge after capture, so only the local copy of the word is read
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_q <= 1'b0;
    end else begin
      load_q <= load_pulse;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      word_q <= '0;
    end else if (le_d2_q) begin
      word_q <= shreg_q;
    end
  end

  assign sel = word_q[SEL_W-1:0];

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_cp_q <= REF_CP_BASE;
      out_cfg_q <= OUT_CFG_BASE;
      // Empty until the host writes it, so a missed load is visible
      fixed_q <= '0;
    end else if (load_q) begin
      if (sel == SEL_REF_CP) begin
        ref_cp_q <= word_q;
      end
      if (sel == SEL_FIXED) begin
        fixed_q <= word_q;
      end
      if (sel == SEL_OUT_CFG) begin
        out_cfg_q <= word_q;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_active_q <= 3'h0;
    end else if (!ref_cp_q[DBUF_BIT]) begin
      div_active_q <= out_cfg_q[DIV_HI:DIV_LO];
    end else if (load_q && sel == SEL_INTEGER) begin
      div_active_q <= out_cfg_q[DIV_HI:DIV_LO];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= lock_detect_in;
      lock_s2_q <= lock_s1_q;
    end
  end

  assign pd = ref_cp_q[PD_BIT];
  assign locked = lock_s2_q & ~pd;
  assign counters_held_out = pd | ref_cp_q[CRST_BIT];

  // R divider stands in for the reference path, run on the local clock
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_cnt_q <= '0;
    end else if (counters_held_out || r_cnt_q + 1'b1 >= r_ratio_out) begin
      r_cnt_q <= '0;
    end else begin
      r_cnt_q <= r_cnt_q + R_W'(1);
    end
  end

  assign r_ratio_out = (ref_cp_q[R_CNT_HI:R_CNT_LO] == '0) ? R_W'(1) : ref_cp_q[R_CNT_HI:R_CNT_LO];
  assign r_tick_out = ~counters_held_out && (r_cnt_q + 1'b1 >= r_ratio_out);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      half_q <= 1'b0;
    end else if (counters_held_out) begin
      half_q <= 1'b0;
    end else if (r_tick_out) begin
      half_q <= ~half_q;
    end
  end

  assign phase_detector_ref_out = reference_halving_enable_out ? half_q : r_tick_out;
  assign test_pin_select_out = ref_cp_q[TEST_SEL_HI:TEST_SEL_LO];
  assign test_pin_logic_level_out = ref_cp_q[LEVEL_BIT];
  assign reference_doubler_enable_out = ref_cp_q[DOUBLER_BIT];
  assign detector_edge_both_out = ref_cp_q[DOUBLER_BIT];
  assign reference_halving_enable_out = ref_cp_q[HALVING_BIT];
  assign pump_current_code_out = ref_cp_q[CP_HI:CP_LO];
  assign reference_differential_out = ref_cp_q[REF_MODE_BIT];
  assign detector_polarity_out = ref_cp_q[POL_BIT];
  assign pump_high_impedance_out = ref_cp_q[HIZ_BIT] | pd;
  assign osc_enable_out = ~pd;
  assign lock_detect_reset_out = pd;
  assign negative_bleed_on_out = out_cfg_q[NEG_BIT] & (~out_cfg_q[GATED_BIT] | locked);
  assign bleed_current_code_out = out_cfg_q[BLEED_HI:BLEED_LO];
  assign feedback_source_select_out = out_cfg_q[FB_BIT];
  assign output_divider_code_out = div_active_q;
  assign rf_allowed = ~pd & (~out_cfg_q[MUTE_BIT] | locked);
  assign primary_rf_output_on_out = out_cfg_q[PRI_EN_BIT] & rf_allowed;
  assign primary_power_out = out_cfg_q[PRI_PW_HI:PRI_PW_LO];
  assign auxiliary_rf_output_on_out = out_cfg_q[AUX_EN_BIT] & rf_allowed;
  assign auxiliary_power_out = out_cfg_q[AUX_PW_HI:AUX_PW_LO];
  assign fixed_word_out = fixed_q;
endmodule

// ---- srcr_checker.sv ----
`timescale 1ns/10ps
module srcr_checker (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load_en
);
  logic clk_q;
  logic [5:0] rise_cnt_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) clk_q <= 1'b0;
    else clk_q <= ser_clk;
  end
  // Cleared by the strobe so every frame is counted on its own
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) rise_cnt_q <= 6'h00;
    else if (ser_load_en) rise_cnt_q <= 6'h00;
    else if (ser_clk && !clk_q) rise_cnt_q <= rise_cnt_q + 6'h01;
  end
  property p_word_len; $rose(ser_load_en) |-> rise_cnt_q == 6'h20; endproperty
  a_word_len: assert property (p_word_len) else $error("bad word length");
  property p_cnt_max; rise_cnt_q <= 6'h20; endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("frame too long");
  property p_strobe; $rose(ser_load_en) |=> ser_load_en ##1 !ser_load_en; endproperty
  a_strobe: assert property (p_strobe) else $error("bad strobe length");
  property p_idle_clk; ser_load_en |-> !ser_clk; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock during strobe");
  property p_clk_high; $rose(ser_clk) |=> ser_clk ##1 !ser_clk; endproperty
  a_clk_high: assert property (p_clk_high) else $error("bad high phase");
  property p_clk_low; $fell(ser_clk) |=> !ser_clk; endproperty
  a_clk_low: assert property (p_clk_low) else $error("bad low phase");
  property p_data_hold; ser_clk |-> $stable(ser_data); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_quiet; $fell(ser_load_en) |-> !ser_clk [*2]; endproperty
  a_quiet: assert property (p_quiet) else $error("clock after strobe");
  c_frame: cover property ($rose(ser_load_en));
  c_clk: cover property ($rose(ser_clk));
  c_end: cover property ($fell(ser_load_en));
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top
  import srcr_pkg::*;
;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, lock_detect_in = 1'b0, word_valid_in = 1'b0;
  logic [31:0] word_in = 32'h0, ref_w, fixed_word_out;
  logic word_ready_out, test_pin_logic_level_out, reference_doubler_enable_out, r_tick_out;
  logic reference_halving_enable_out, detector_edge_both_out, phase_detector_ref_out;
  logic reference_differential_out, detector_polarity_out, pump_high_impedance_out;
  logic counters_held_out, osc_enable_out, lock_detect_reset_out, negative_bleed_on_out;
  logic feedback_source_select_out, primary_rf_output_on_out, auxiliary_rf_output_on_out;
  logic [1:0] primary_power_out, auxiliary_power_out;
  logic [2:0] test_pin_select_out, output_divider_code_out;
  logic [3:0] pump_current_code_out;
  logic [7:0] bleed_current_code_out;
  logic [9:0] r_ratio_out;
  int fail_count = 0, compares = 0;
  srcr_if link_if ();
  srcr_host srcr_host_inst (.link(link_if), .*);
  srcr_device srcr_device_inst (.link(link_if), .*);
  srcr_checker chk_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ser_clk(link_if.ser_clk),
    .ser_data(link_if.ser_data), .ser_load_en(link_if.ser_load_en));
  always #12.5 ref_clk_in = ~ref_clk_in;
  task automatic conclude();
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input logic [31:0] w);
    int n;
    for (n = 0; n < 400 && word_ready_out !== 1'b1; n++) @(negedge ref_clk_in);
    word_in = w;
    word_valid_in = 1'b1;
    @(negedge ref_clk_in);
    word_valid_in = 1'b0;
    for (n = 0; n < 400 && word_ready_out !== 1'b1; n++) @(negedge ref_clk_in);
    // Covers the load-to-register latency with margin
    repeat (8) @(negedge ref_clk_in);
  endtask
  task automatic t_ref(input logic [31:0] w);
    int n;
    logic p0;
    ref_w = w;
    send(w);
    `CHK(test_pin_select_out, w[29:27])
    `CHK(test_pin_logic_level_out, w[8])
    `CHK({reference_doubler_enable_out, detector_edge_both_out}, {2{w[26]}})
    `CHK(reference_halving_enable_out, w[25])
    `CHK(r_ratio_out, w[24:15])
    `CHK(pump_current_code_out, w[13:10])
    `CHK(reference_differential_out, w[9])
    `CHK(detector_polarity_out, w[7])
    `CHK(pump_high_impedance_out, w[5])
    `CHK(counters_held_out, w[4])
    for (n = 0; n < 1100 && r_tick_out !== 1'b1; n++) @(negedge ref_clk_in);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (r_tick_out !== 1'b1 && n < 1100);
    `CHK(n, int'(w[24:15]))
    p0 = phase_detector_ref_out;
    @(negedge ref_clk_in);
    `CHK(phase_detector_ref_out, w[25] ? ~p0 : (w[24:15] == 10'h001))
  endtask
  task automatic t_out(input logic [31:0] w);
    send(w);
    `CHK(negative_bleed_on_out, w[29])
    `CHK(feedback_source_select_out, w[24])
    `CHK(output_divider_code_out, w[23:21])
    `CHK(bleed_current_code_out, w[20:13])
    `CHK({auxiliary_rf_output_on_out, auxiliary_power_out}, w[9:7])
    `CHK({primary_rf_output_on_out, primary_power_out}, w[6:4])
    `CHK(pump_current_code_out, ref_w[13:10])
  endtask
  task automatic t_pd();
    send(ref_w | 32'h0000_0040);
    `CHK({osc_enable_out, pump_high_impedance_out, counters_held_out}, 3'h3)
    `CHK({lock_detect_reset_out, primary_rf_output_on_out, auxiliary_rf_output_on_out}, 3'h4)
    `CHK(pump_current_code_out, ref_w[13:10])
    send(ref_w);
  endtask
  task automatic t_gate();
    send(OUT_CFG_BASE | 32'h6000_0840);
    `CHK({negative_bleed_on_out, primary_rf_output_on_out}, 2'h0)
    lock_detect_in = 1'b1;
    // Lock input passes a two-stage synchroniser
    repeat (4) @(negedge ref_clk_in);
    `CHK({negative_bleed_on_out, primary_rf_output_on_out}, 2'h3)
    lock_detect_in = 1'b0;
  endtask
  task automatic t_dbuf();
    send(ref_w | 32'h0000_4010);
    `CHK(counters_held_out, 1'b1)
    send(OUT_CFG_BASE | 32'h00a0_0000);
    `CHK(output_divider_code_out, 3'h0)
    send(32'h0000_0010);
    `CHK(output_divider_code_out, 3'h5)
    send(32'hffff_fff7);
    `CHK(bleed_current_code_out, 8'h00)
    send(FIXED_WORD);
    `CHK(fixed_word_out, FIXED_WORD)
  endtask
  initial begin
    repeat (10) @(negedge ref_clk_in);
    rst_in = 1'b0;
    @(negedge ref_clk_in);
    t_ref(32'h2fff_a7a4);
    t_ref(32'h1000_9804);
    t_out(32'h142b_40a6);
    t_out(32'h35d4_a356);
    t_pd();
    t_gate();
    t_dbuf();
    conclude();
  end
  initial begin
    #500us;
    fail_count++;
    conclude();
  end
endmodule
